// ==== logic/srp_regs.svh ====
// Constants for the serial register port with CRC and its controller.
// Assumes inclusion by srp_pkg and by every design file that needs it.
//
// Overview of operation
// - Frame opens with 7-bit address, then R/W.
// - Sample on clock rise, drive on fall.
// - Data out floats while chip select high.
// - Host holds select low for whole frame.
// - 16 clocks plain, 24 clocks with CRC.
// - Wrong clock count sets frame error flag.
// - Wrong count with CRC sets CRC error.
// - Host never writes with odd clock counts.
// - After eight clocks, fetch addressed register.
// - Write stores received byte in register.
// - Read data leaves on falling edges, eight bits.
// - CRC off at reset, enabled by bit zero.
// - Default CRC: 2F, init FF, xorout FF.
// - Poly register bit zero picks J1850 CRC8.
// - Filler 00 enters CRC on reads.
// - Host leaves unlisted addresses alone.
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH
`define SRP_ADDR_CRC_CNTL 7'h0A
`define SRP_ADDR_CRC_POLY 7'h0B
`define SRP_ADDR_SCRATCH  7'h0F
`define SRP_ADDR_INT_STAT 7'h51
`define SRP_ADDR_INT_MASK 7'h56
`define SRP_INT_FRAME_BIT 0
`define SRP_INT_CRC_BIT   1
`define SRP_BITS_PLAIN    5'h10
`define SRP_BITS_CRC      5'h18
`define SRP_BYTE_BITS     5'h08
`define SRP_CMD_WRITE     1'b1
`define SRP_FILLER        8'h00
`define SRP_POLY_DEFAULT  8'h2F
`define SRP_POLY_J1850    8'h1D
`define SRP_CRC_INIT      8'hFF
`define SRP_CRC_XOROUT    8'hFF
`define SRP_SCLK_HALF     4'h8
`define SRP_HA_TXDATA     3'h0
`define SRP_HA_CMD        3'h1
`define SRP_HA_CFG        3'h2
`define SRP_HA_STAT       3'h3
`define SRP_HA_MASK       3'h4
`define SRP_HA_RXDATA     3'h5
`define SRP_HST_DONE_BIT  0
`define SRP_HST_CRC_BIT   1
`define SRP_HST_BUSY_BIT  2
`endif

// ==== logic/srp_pkg.sv ====
// Types and CRC arithmetic shared by both ends of the serial port.
// Assumes srp_regs.svh is on the include path.
`include "srp_regs.svh"
package srp_pkg;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_LOW  = 3'b001,
      HS_HIGH = 3'b010,
      HS_TAIL = 3'b011,
      HS_GAP  = 3'b100
   } srp_hstate_t;

   // One CRC step, MSB first, no reflection.
   function automatic logic [7:0] srp_crc_bit(input logic [7:0] c,
                                              input logic       d,
                                              input logic       sel);
      logic [7:0] poly;
      poly = sel ? `SRP_POLY_J1850 : `SRP_POLY_DEFAULT;
      return (c[7] ^ d) ? ({c[6:0], 1'b0} ^ poly) : {c[6:0], 1'b0};
   endfunction

   // A whole byte through the CRC, MSB first.
   function automatic logic [7:0] srp_crc_byte(input logic [7:0] c,
                                               input logic [7:0] b,
                                               input logic       sel);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = srp_crc_bit(r, b[i], sel);
      end
      return r;
   endfunction

   // Finished CRC of a command byte and a data byte.
   function automatic logic [7:0] srp_crc_frame(input logic [7:0] cmd,
                                                input logic [7:0] dat,
                                                input logic       sel);
      return srp_crc_byte(srp_crc_byte(`SRP_CRC_INIT, cmd, sel), dat, sel)
             ^ `SRP_CRC_XOROUT;
   endfunction

   typedef struct packed {
      logic [7:0] crc;
   } srp_crc_state_t;

   typedef struct packed {
      logic       cs_s1, cs_s2, cs_d;
      logic       ck_s1, ck_s2, ck_d;
      logic       di_s1, di_s2;
      logic [4:0] cnt;
      logic [7:0] sh;
      logic [7:0] cmd;
      logic [7:0] dat;
      logic [7:0] tx;
      logic       sdo;
      logic       crc_en;
      logic       poly_sel;
      logic [7:0] scratch;
      logic [1:0] stat;
      logic [1:0] mask;
   } srp_dev_state_t;

   typedef struct packed {
      srp_hstate_t st;
      logic [3:0]  tmr;
      logic [4:0]  bitn;
      logic [23:0] tx;
      logic [15:0] rx;
      logic        cs_n, sclk, sdi;
      logic        do_s1, do_s2;
      logic [7:0]  txdata, cmd, rxdata, rdata;
      logic        crc_en, poly_sel;
      logic [1:0]  stat, mask;
   } srp_host_state_t;

endpackage

// ==== logic/srp_if.sv ====
// Serial link between the register port and its controller.
// Assumes a pull-up on the data-out wire while the device does not drive.
`timescale 1ns/1ns
interface srp_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;

   // Resolved data-out wire; idle level is high.
   assign sdo = sdo_oe ? sdo_o : 1'b1;

   modport dev (input cs_n, input sclk, input sdi,
                output sdo_o, output sdo_oe);
   modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface

// ==== logic/srp_crc8.sv ====
// Serial CRC8 accumulator, one bit per enable.
// Assumes inputs are on ref_clk and clr and en are never both needed.
`timescale 1ns/1ns
module srp_crc8 (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic       clr,
   input  wire logic       en,
   input  wire logic       din,
   input  wire logic       poly_sel,
   output logic [7:0]      crc
);
   import srp_pkg::*;

   srp_pkg::srp_crc_state_t s_reg, s_next;

   // Restart at the initial value or take one bit.
   always_comb begin
      s_next = s_reg;
      if (clr) begin
         s_next.crc = `SRP_CRC_INIT;
      end else if (en) begin
         s_next.crc = srp_crc_bit(s_reg.crc, din, poly_sel);
      end
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_reg <= '{crc: `SRP_CRC_INIT};
      end else begin
         s_reg <= s_next;
      end
   end

   assign crc = s_reg.crc;
endmodule

// ==== logic/srp_dev.sv ====
// Device end: serial register port with CRC, error flags and interrupt.
// Assumes the link pins are asynchronous to ref_clk and that sclk
// stays at least three ref_clk periods in each level.
`timescale 1ns/1ns
module srp_dev (
   input  wire logic ref_clk,
   input  wire logic srst,
   srp_if.dev        link,
   output logic      irq,
   output logic      crc_on
);
   import srp_pkg::*;

   srp_pkg::srp_dev_state_t s_reg, s_next;

   logic       active;
   logic       ck_rise;
   logic       ck_fall;
   logic       cs_fall;
   logic       cs_rise;
   logic       is_write;
   logic       cnt_ok;
   logic       crc_ok;
   logic [4:0] cnt_exp;
   logic [7:0] rd_data;
   logic [7:0] rx_crc;
   logic [1:0] st_set;
   logic [1:0] st_clr;

   ////////////////////////////////////////////////////////////////////
   // Register read decode.
   ////////////////////////////////////////////////////////////////////

   // Unlisted addresses read as zero and ignore writes.
   function automatic logic [7:0] reg_read(input srp_dev_state_t s,
                                           input logic [6:0]     a);
      unique case (a)
         `SRP_ADDR_CRC_CNTL: return {7'h00, s.crc_en};
         `SRP_ADDR_CRC_POLY: return {7'h00, s.poly_sel};
         `SRP_ADDR_SCRATCH:  return s.scratch;
         `SRP_ADDR_INT_STAT: return {6'h00, s.stat};
         `SRP_ADDR_INT_MASK: return {6'h00, s.mask};
         default:            return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Edge detection on the synchronised pins.
   ////////////////////////////////////////////////////////////////////

   // Edges come from the second and third stages only.
   assign active  = ~s_reg.cs_s2;
   assign ck_rise = active & s_reg.ck_s2 & ~s_reg.ck_d;
   assign ck_fall = active & ~s_reg.ck_s2 & s_reg.ck_d;
   assign cs_fall = ~s_reg.cs_s2 & s_reg.cs_d;
   assign cs_rise = s_reg.cs_s2 & ~s_reg.cs_d;

   // Read data for the addressed register, from the first byte.
   assign rd_data  = reg_read(s_reg, s_reg.cmd[7:1]);
   assign is_write = (s_reg.cmd[0] == `SRP_CMD_WRITE);

   ////////////////////////////////////////////////////////////////////
   // Receive CRC over command and data bytes.
   ////////////////////////////////////////////////////////////////////

   // Only the first sixteen bits enter the check.
   srp_crc8 u_rx_crc (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clr      (cs_fall),
      .en       (ck_rise && (s_reg.cnt < `SRP_BITS_PLAIN)),
      .din      (s_reg.di_s2),
      .poly_sel (s_reg.poly_sel),
      .crc      (rx_crc)
   );

   ////////////////////////////////////////////////////////////////////
   // Frame end checks.
   ////////////////////////////////////////////////////////////////////

   // Expected clock count follows the CRC enable.
   assign cnt_exp = s_reg.crc_en ? `SRP_BITS_CRC : `SRP_BITS_PLAIN;
   assign cnt_ok  = (s_reg.cnt == cnt_exp);
   // The last byte shifted in is the received CRC.
   assign crc_ok  = ~s_reg.crc_en ||
                    (s_reg.sh == (rx_crc ^ `SRP_CRC_XOROUT));

   // Error events raised at the close of a frame.
   always_comb begin
      st_set = 2'b00;
      if (cs_rise) begin
         if (!cnt_ok) begin
            st_set[`SRP_INT_FRAME_BIT] = 1'b1;
            st_set[`SRP_INT_CRC_BIT]   = s_reg.crc_en;
         end else if (!crc_ok) begin
            st_set[`SRP_INT_CRC_BIT] = 1'b1;
         end
      end
   end

   // Write-one-to-clear of the status through a good write frame.
   always_comb begin
      st_clr = 2'b00;
      if (cs_rise && cnt_ok && crc_ok && is_write &&
          (s_reg.cmd[7:1] == `SRP_ADDR_INT_STAT)) begin
         st_clr = s_reg.dat[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next state.
   ////////////////////////////////////////////////////////////////////

   always_comb begin
      s_next = s_reg;
      // Two-stage synchronisers, plus one stage for edge finding.
      s_next.cs_s1 = link.cs_n;
      s_next.cs_s2 = s_reg.cs_s1;
      s_next.cs_d  = s_reg.cs_s2;
      s_next.ck_s1 = link.sclk;
      s_next.ck_s2 = s_reg.ck_s1;
      s_next.ck_d  = s_reg.ck_s2;
      s_next.di_s1 = link.sdi;
      s_next.di_s2 = s_reg.di_s1;

      // A new frame starts from a clean count and a quiet output.
      if (cs_fall) begin
         s_next.cnt = 5'h00;
         s_next.sdo = 1'b0;
         s_next.tx  = 8'h00;
      end

      // Capture on the rising clock edge.
      if (ck_rise) begin
         s_next.sh = {s_reg.sh[6:0], s_reg.di_s2};
         if (s_reg.cnt != 5'h1F) begin
            s_next.cnt = s_reg.cnt + 5'h01;
         end
         // First byte complete: address and command, fetch.
         if (s_reg.cnt == `SRP_BYTE_BITS - 5'h01) begin
            s_next.cmd = {s_reg.sh[6:0], s_reg.di_s2};
            s_next.tx  = reg_read(s_reg, s_reg.sh[6:0]);
            if ({s_reg.sh[0], s_reg.di_s2} == {1'b0, `SRP_CMD_WRITE}
                || s_reg.di_s2 == `SRP_CMD_WRITE) begin
               s_next.tx = 8'h00;
            end
         end
         // Second byte complete: data, then the outgoing CRC.
         if (s_reg.cnt == `SRP_BITS_PLAIN - 5'h01) begin
            s_next.dat = {s_reg.sh[6:0], s_reg.di_s2};
            s_next.tx  = 8'h00;
            if (!is_write && s_reg.crc_en) begin
               s_next.tx = srp_crc_frame(s_reg.cmd, rd_data,
                                         s_reg.poly_sel);
            end
         end
      end

      // Drive on the falling clock edge once the first byte is in.
      if (ck_fall && (s_reg.cnt >= `SRP_BYTE_BITS)) begin
         s_next.sdo = s_reg.tx[7];
         s_next.tx  = {s_reg.tx[6:0], 1'b0};
      end

      // Commit a write only from a frame of the right length and CRC.
      if (cs_rise && cnt_ok && crc_ok && is_write) begin
         unique case (s_reg.cmd[7:1])
            `SRP_ADDR_CRC_CNTL: s_next.crc_en   = s_reg.dat[0];
            `SRP_ADDR_CRC_POLY: s_next.poly_sel = s_reg.dat[0];
            `SRP_ADDR_SCRATCH:  s_next.scratch  = s_reg.dat;
            `SRP_ADDR_INT_MASK: s_next.mask     = s_reg.dat[1:0];
            default: ;
         endcase
      end

      // Sticky status: a new event wins over a clear in the same cycle.
      s_next.stat = (s_reg.stat & ~st_clr) | st_set;
   end

   ////////////////////////////////////////////////////////////////////
   // State register.
   ////////////////////////////////////////////////////////////////////

   // CRC starts off and the default polynomial is selected.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
                    default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs.
   ////////////////////////////////////////////////////////////////////

   // Output driver only while chip select is low.
   assign link.sdo_oe = active;
   assign link.sdo_o  = s_reg.sdo;
   assign irq         = |(s_reg.stat & s_reg.mask);
   assign crc_on      = s_reg.crc_en;
endmodule

// ==== logic/srp_host.sv ====
// Controller end: runs frames on the serial link at software request.
// Assumes the plain register port is on ref_clk; sdo is asynchronous.
`timescale 1ns/1ns
module srp_host (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   output logic            irq,
   srp_if.host             link
);
   import srp_pkg::*;

   srp_pkg::srp_host_state_t s_reg, s_next;

   logic       busy;
   logic       tmr_done;
   logic [4:0] last_bit;
   logic [7:0] db;
   logic [7:0] rx_dat;
   logic [1:0] st_set;
   logic [1:0] st_clr;

   assign busy     = (s_reg.st != HS_IDLE);
   assign tmr_done = (s_reg.tmr == 4'h0);
   assign last_bit = (s_reg.crc_en ? `SRP_BITS_CRC : `SRP_BITS_PLAIN)
                     - 5'h01;
   // Reads carry the filler byte in place of data.
   assign db = (wdata[0] == `SRP_CMD_WRITE) ? s_reg.txdata
                                           : `SRP_FILLER;
   assign rx_dat = s_reg.crc_en ? s_reg.rx[15:8] : s_reg.rx[7:0];

   // Frame completion and read CRC mismatch events.
   always_comb begin
      st_set = 2'b00;
      st_clr = 2'b00;
      if (s_reg.st == HS_TAIL && tmr_done) begin
         st_set[`SRP_HST_DONE_BIT] = 1'b1;
         st_set[`SRP_HST_CRC_BIT]  = s_reg.crc_en &&
            (s_reg.cmd[0] != `SRP_CMD_WRITE) &&
            (s_reg.rx[7:0] != srp_crc_frame(s_reg.cmd, rx_dat,
                                            s_reg.poly_sel));
      end
      if (wr && addr == `SRP_HA_STAT) begin
         st_clr = wdata[1:0];
      end
   end

   always_comb begin
      s_next       = s_reg;
      s_next.do_s1 = link.sdo;
      s_next.do_s2 = s_reg.do_s1;
      s_next.tmr   = tmr_done ? 4'h0 : s_reg.tmr - 4'h1;
      // Software writes; a command while busy is ignored.
      if (wr) begin
         unique case (addr)
            `SRP_HA_TXDATA: s_next.txdata = wdata;
            `SRP_HA_CFG: begin
               s_next.crc_en   = wdata[0];
               s_next.poly_sel = wdata[1];
            end
            `SRP_HA_MASK: s_next.mask = wdata[1:0];
            `SRP_HA_CMD: begin
               if (!busy) begin
                  s_next.cmd  = wdata;
                  s_next.tx   = {wdata, db,
                                 srp_crc_frame(wdata, db, s_reg.poly_sel)};
                  s_next.cs_n = 1'b0;
                  s_next.sdi  = wdata[7];
                  s_next.bitn = 5'h00;
                  s_next.tmr  = `SRP_SCLK_HALF - 4'h1;
                  s_next.st   = HS_LOW;
               end
            end
            default: ;
         endcase
      end
      // Clock generator and bit sequencer.
      unique case (s_reg.st)
         HS_IDLE: ;
         HS_LOW: if (tmr_done) begin
            s_next.sclk = 1'b1;
            s_next.rx   = {s_reg.rx[14:0], s_reg.do_s2};
            s_next.tmr  = `SRP_SCLK_HALF - 4'h1;
            s_next.st   = HS_HIGH;
         end
         HS_HIGH: if (tmr_done) begin
            s_next.sclk = 1'b0;
            s_next.tmr  = `SRP_SCLK_HALF - 4'h1;
            if (s_reg.bitn == last_bit) begin
               s_next.st = HS_TAIL;
            end else begin
               s_next.bitn = s_reg.bitn + 5'h01;
               s_next.tx   = {s_reg.tx[22:0], 1'b0};
               s_next.sdi  = s_reg.tx[22];
               s_next.st   = HS_LOW;
            end
         end
         HS_TAIL: if (tmr_done) begin
            s_next.cs_n   = 1'b1;
            s_next.rxdata = rx_dat;
            s_next.tmr    = `SRP_SCLK_HALF - 4'h1;
            s_next.st     = HS_GAP;
         end
         HS_GAP: if (tmr_done) begin
            s_next.st = HS_IDLE;
         end
         default: s_next.st = HS_IDLE;
      endcase
      // Register read data, one cycle after the strobe.
      s_next.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            `SRP_HA_TXDATA: s_next.rdata = s_reg.txdata;
            `SRP_HA_CMD:    s_next.rdata = s_reg.cmd;
            `SRP_HA_CFG:    s_next.rdata = {6'h00, s_reg.poly_sel,
                                            s_reg.crc_en};
            `SRP_HA_STAT:   s_next.rdata = {5'h00, busy, s_reg.stat};
            `SRP_HA_MASK:   s_next.rdata = {6'h00, s_reg.mask};
            `SRP_HA_RXDATA: s_next.rdata = s_reg.rxdata;
            default: ;
         endcase
      end
      // Set wins over clear.
      s_next.stat = (s_reg.stat & ~st_clr) | st_set;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_reg <= '{st: HS_IDLE, cs_n: 1'b1, do_s1: 1'b1, do_s2: 1'b1,
                    default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign link.cs_n = s_reg.cs_n;
   assign link.sclk = s_reg.sclk;
   assign link.sdi  = s_reg.sdi;
   assign rdata     = s_reg.rdata;
   assign irq       = |(s_reg.stat & s_reg.mask);
endmodule

// ==== test/srp_link_assertions.sv ====
// Checker for the serial link joining the port's two ends.
// Assumes plain inputs wired by the bench from the interface signals.
`timescale 1ns/1ns
module srp_link_assertions (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic sdo
);
   logic [8:0] low_reg;
   logic [4:0] rise_reg;
   logic       sclk_reg;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////
   // Counts selected cycles and clock rises within one frame.
   always_ff @(posedge ref_clk) begin
      if (srst || cs_n) begin
         low_reg  <= 9'h000;
         rise_reg <= 5'h00;
      end else begin
         low_reg  <= low_reg + 9'h001;
         rise_reg <= rise_reg + {4'h0, sclk & ~sclk_reg};
      end
      sclk_reg <= sclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Named pieces of the clock waveform.
   sequence s_low8;
      !sclk [*8];
   endsequence
   sequence s_high8;
      sclk [*8];
   endsequence

   property p_float;
      cs_n [*4] |-> !sdo_oe;
   endproperty
   property p_drive;
      !cs_n [*4] |-> sdo_oe;
   endproperty
   property p_sdi;
      $changed(sdi) |-> !sclk;
   endproperty
   property p_sdo;
      sdo_oe && $changed(sdo_o) |-> !sclk;
   endproperty
   property p_idle;
      cs_n |-> !sclk;
   endproperty
   property p_lead;
      $fell(cs_n) |-> s_low8;
   endproperty
   property p_high;
      $rose(sclk) |-> s_high8 ##1 !sclk;
   endproperty
   property p_low;
      $fell(sclk) |-> s_low8;
   endproperty
   property p_count;
      $rose(cs_n) |-> (rise_reg == 5'h10 && low_reg == 9'h108) ||
                      (rise_reg == 5'h18 && low_reg == 9'h188);
   endproperty
   property p_gap;
      $rose(cs_n) |-> cs_n [*8];
   endproperty
   property p_pull;
      cs_n [*4] |-> sdo;
   endproperty

   a_float: assert property (p_float)
      else $error("Data out driven while deselected.");
   a_drive: assert property (p_drive)
      else $error("Data out not driven while selected.");
   a_sdi: assert property (p_sdi)
      else $error("Host data changed while clock high.");
   a_sdo: assert property (p_sdo)
      else $error("Device data changed while clock high.");
   a_idle: assert property (p_idle)
      else $error("Clock high while deselected.");
   a_lead: assert property (p_lead)
      else $error("Clock rose too soon after select.");
   a_high: assert property (p_high)
      else $error("Clock high phase has wrong length.");
   a_low: assert property (p_low)
      else $error("Clock low phase too short.");
   a_count: assert property (p_count)
      else $error("Frame has wrong clock count or length.");
   a_gap: assert property (p_gap)
      else $error("Gap between frames too short.");
   a_pull: assert property (p_pull)
      else $error("Data wire not released high while deselected.");
endmodule

// ==== test/spi_register_port_with_crc_tb.sv ====
// Bench for both port ends joined by a link, plus a bench-driven link.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ns
`include "srp_regs.svh"
module spi_register_port_with_crc_tb;
   import srp_pkg::*;
   logic        ref_clk, srst, wr, rd;
   logic [2:0]  addr;
   logic [7:0]  wdata, rdata;
   logic        h_irq, d_irq, d_crc, d2_irq, d2_crc;
   logic [31:0] rs;
   logic [7:0]  model_q[$];
   int          errors, checks_done;
   srp_if l1 ();
   srp_if l2 ();

   srp_dev srp_dev_inst (.ref_clk(ref_clk), .srst(srst), .link(l1.dev),
      .irq(d_irq), .crc_on(d_crc));
   srp_dev srp_dev_inst_2 (.ref_clk(ref_clk), .srst(srst), .link(l2.dev),
      .irq(d2_irq), .crc_on(d2_crc));
   srp_host srp_host_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(h_irq),
      .link(l1.host));
   srp_link_assertions srp_link_assertions_inst (.ref_clk(ref_clk),
      .srst(srst), .cs_n(l1.cs_n), .sclk(l1.sclk), .sdi(l1.sdi),
      .sdo_o(l1.sdo_o), .sdo_oe(l1.sdo_oe), .sdo(l1.sdo));

   ////////////////////////////////////////////////////////////////////////
   // Clock of 100 ns period.
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   // Compares one value and counts the outcome.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Xorshift source of stimulus.
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   // Reference CRC of a command and a data byte, MSB first.
   function automatic logic [7:0] ref_crc(input logic [15:0] m,
                                          input logic j);
      logic [7:0] c;
      logic [7:0] p;
      c = `SRP_CRC_INIT;
      p = j ? `SRP_POLY_J1850 : `SRP_POLY_DEFAULT;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? p : 8'h00);
      end
      return c ^ `SRP_CRC_XOROUT;
   endfunction

   // One-cycle write strobe on the plain port.
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   // One-cycle read strobe; data taken in the following cycle.
   task automatic rreg(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      @(posedge ref_clk);
      v = rdata;
   endtask

   // Runs one controller frame and returns the received byte.
   task automatic hframe(input logic [6:0] a, input logic w,
                         input logic [7:0] d, output logic [7:0] rx);
      logic [7:0] v;
      wreg(`SRP_HA_TXDATA, d);
      wreg(`SRP_HA_CMD, {a, w});
      v = 8'h04;
      for (int k = 0; k < 300 && v[2]; k++) rreg(`SRP_HA_STAT, v);
      if (v[2]) errors++;
      rreg(`SRP_HA_RXDATA, rx);
   endtask

   // Bench frame of n clocks on the second link, 800 ns clock period.
   task automatic bang(input int n, input logic [23:0] v,
                       output logic [23:0] g);
      g = 24'h000000;
      l2.cs_n <= 1'b0;
      l2.sdi  <= v[23];
      repeat (4) @(posedge ref_clk);
      for (int i = 1; i <= n; i++) begin
         l2.sclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         g = {g[22:0], l2.sdo};
         l2.sclk <= 1'b0;
         l2.sdi  <= (i < 24) ? v[23-i] : 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      l2.cs_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      close_out();
   end

   // Main sequence of scenarios.
   initial begin
      logic [7:0]  v;
      logic [7:0]  d;
      logic [7:0]  c;
      logic [23:0] g;
      srst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      rs = 32'h0000003A;
      errors = 0;
      checks_done = 0;
      l2.cs_n = 1'b1;
      l2.sclk = 1'b0;
      l2.sdi = 1'b0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      rreg(`SRP_HA_CFG, v);
      chk(v, 8'h00);
      rreg(3'h6, v);
      chk(v, 8'h00);
      chk({7'h00, d_crc}, 8'h00);
      // Plain write then read back of the scratch register, via the model.
      repeat (3) begin
         d = 8'(rnd());
         hframe(`SRP_ADDR_SCRATCH, `SRP_CMD_WRITE, d, v);
         model_q.push_back(d);
         hframe(`SRP_ADDR_SCRATCH, 1'b0, `SRP_FILLER, v);
         chk(v, model_q.pop_front());
      end
      // Controller completion interrupt: mask, raise, clear.
      rreg(`SRP_HA_STAT, v);
      chk(v, 8'h01);
      wreg(`SRP_HA_MASK, 8'h01);
      repeat (2) @(posedge ref_clk);
      chk({7'h00, h_irq}, 8'h01);
      wreg(`SRP_HA_STAT, 8'h01);
      repeat (2) @(posedge ref_clk);
      chk({7'h00, h_irq}, 8'h00);
      // CRC frames under each polynomial.
      hframe(`SRP_ADDR_CRC_CNTL, 1'b1, 8'h01, v);
      chk({7'h00, d_crc}, 8'h01);
      wreg(`SRP_HA_CFG, 8'h01);
      for (int p = 0; p < 2; p++) begin
         hframe(`SRP_ADDR_CRC_POLY, 1'b1, 8'(p), v);
         wreg(`SRP_HA_CFG, {6'h00, 1'(p), 1'b1});
         d = 8'(rnd());
         hframe(`SRP_ADDR_SCRATCH, 1'b1, d, v);
         hframe(`SRP_ADDR_SCRATCH, 1'b0, `SRP_FILLER, v);
         chk(v, d);
         rreg(`SRP_HA_STAT, v);
         chk(v & 8'h02, 8'h00);
      end
      // Polynomial mismatch: write refused, both ends flag it.
      wreg(`SRP_HA_CFG, 8'h01);
      hframe(`SRP_ADDR_SCRATCH, 1'b1, ~d, v);
      hframe(`SRP_ADDR_SCRATCH, 1'b0, `SRP_FILLER, v);
      rreg(`SRP_HA_STAT, v);
      chk(v & 8'h02, 8'h02);
      wreg(`SRP_HA_CFG, 8'h03);
      hframe(`SRP_ADDR_SCRATCH, 1'b0, `SRP_FILLER, v);
      chk(v, d);
      hframe(`SRP_ADDR_INT_STAT, 1'b0, `SRP_FILLER, v);
      chk(v & 8'h02, 8'h02);
      hframe(`SRP_ADDR_INT_MASK, 1'b1, 8'h03, v);
      chk({7'h00, d_irq}, 8'h01);
      hframe(`SRP_ADDR_INT_STAT, 1'b1, 8'h03, v);
      chk({7'h00, d_irq}, 8'h00);
      // Wrong clock counts on the bench link, CRC off.
      @(posedge ref_clk);
      for (int n = 15; n <= 17; n += 2) begin
         bang(n, 24'h1E0000, g);
         bang(16, 24'hA20000, g);
         chk(g[7:0], 8'h01);
         bang(16, 24'hA30100, g);
      end
      // Wrong clock count with CRC on, then a checked status read.
      bang(16, 24'h150100, g);
      chk({7'h00, d2_crc}, 8'h01);
      bang(25, 24'h1E0000, g);
      c = ref_crc(16'hA200, 1'b0);
      bang(24, {16'hA200, c}, g);
      chk(g[15:8], 8'h03);
      chk(g[7:0], ref_crc(16'hA203, 1'b0));
      chk({7'h00, d2_irq}, 8'h00);
      close_out();
   end
endmodule
